/* verilog/cmk_unit.sv */
// Compare and clock mode execution unit with AXI4-Lite register access
`timescale 1ns/1ps
`include "cmk_defs.svh"
module cmk_unit #(
  parameter int REG_COUNT = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] clock_mode,
  output logic busy
);

  localparam int RW = $clog2(REG_COUNT);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cmk_pkg::cmk_state_t state_ff;
  cmk_pkg::cmk_state_t nxt_state;
  logic [31:0] regs_ff [REG_COUNT];
  logic [31:0] instr_ff;
  logic [2:0] ctrl_ff;
  logic zero_ff;
  logic carry_ff;
  logic ill_ff;
  logic [31:0] result_ff;
  logic [7:0] clkmode_ff;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [3:0] hub_phase_ff;
  logic [31:0] dst_ff;
  logic [31:0] src_ff;
  logic sgn_ff;
  logic [8:0] dst_idx_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire aw_take = s_axi_awvalid && !aw_got_ff && !bvalid_ff;
  wire w_take = s_axi_wvalid && !w_got_ff && !bvalid_ff;
  wire wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  wire ar_take = s_axi_arvalid && !rvalid_ff;
  wire wa_reg = awaddr_ff >= `CMK_OFF_REGBASE;
  wire [RW-1:0] wa_idx = awaddr_ff[RW+1:2];
  wire ra_reg = s_axi_araddr >= `CMK_OFF_REGBASE;
  wire [RW-1:0] ra_idx = s_axi_araddr[RW+1:2];
  wire wr_instr = wr_go && awaddr_ff == `CMK_OFF_INSTR;
  wire wr_ctrl = wr_go && awaddr_ff == `CMK_OFF_CTRL;
  wire wr_regf = wr_go && wa_reg;
  wire wr_ok = wr_instr || wr_ctrl || wr_regf;
  wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                       {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] st_word = {28'h0000000, ill_ff, carry_ff, zero_ff,
                         state_ff != cmk_pkg::CMK_IDLE};
  wire ra_known = ra_reg || s_axi_araddr == `CMK_OFF_INSTR ||
                  s_axi_araddr == `CMK_OFF_CTRL ||
                  s_axi_araddr == `CMK_OFF_STATUS ||
                  s_axi_araddr == `CMK_OFF_RESULT ||
                  s_axi_araddr == `CMK_OFF_CLKMODE;
  wire [31:0] rd_mux =
    ra_reg ? regs_ff[ra_idx] :
    s_axi_araddr == `CMK_OFF_INSTR ? instr_ff :
    s_axi_araddr == `CMK_OFF_CTRL ? {29'h0, ctrl_ff} :
    s_axi_araddr == `CMK_OFF_STATUS ? st_word :
    s_axi_araddr == `CMK_OFF_RESULT ? result_ff :
    s_axi_araddr == `CMK_OFF_CLKMODE ? {24'h000000, clkmode_ff} :
    32'h00000000;

  // ----------------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------------
  wire [31:0] new_instr = (instr_ff & ~wmask) | (wdata_ff & wmask);
  wire [5:0] f_op = new_instr[`CMK_INSTR_HI:`CMK_INSTR_LO];
  wire [3:0] f_zcri = new_instr[`CMK_ZCRI_HI:`CMK_ZCRI_LO];
  wire [3:0] f_cond = new_instr[`CMK_COND_HI:`CMK_COND_LO];
  wire [8:0] f_dst = new_instr[`CMK_DEST_HI:`CMK_DEST_LO];
  wire [8:0] f_src = new_instr[`CMK_SRC_HI:`CMK_SRC_LO];
  wire f_imm = f_zcri[0];
  wire cond_ok = f_cond == `CMK_COND_ALWAYS;
  wire cmp_zcri = f_zcri[3:1] == `CMK_ZCRI_CMP;
  wire is_ucmp = f_op == `CMK_OP_UCMP && cmp_zcri && cond_ok;
  wire is_scmp = f_op == `CMK_OP_SCMP && cmp_zcri && cond_ok;
  wire is_clk = f_op == `CMK_OP_CLK && f_zcri == `CMK_ZCRI_CLK &&
                cond_ok && f_src == 9'h000;
  wire idle = state_ff == cmk_pkg::CMK_IDLE;
  wire issue = wr_instr && idle;
  wire [RW-1:0] dsel = f_dst[RW-1:0];
  wire [RW-1:0] ssel = f_src[RW-1:0];
  wire [31:0] dst_val = regs_ff[dsel];
  wire [31:0] src_val = f_imm ? {23'h0, f_src}
                              : regs_ff[ssel];
  // Cycles to the next hub slot decide the wait, 7 to 22 in all
  wire [4:0] hub_wait = 5'(`CMK_HUB_MIN) +
                        5'(4'(`CMK_HUB_PERIOD - 1) - hub_phase_ff);

  cmk_pkg::cmk_operands_t ops;
  cmk_pkg::cmk_cmp_result_t res;
  assign ops = '{dst: dst_ff, src: src_ff, is_signed: sgn_ff};

  cmk_comparator u_cmp (
    .ops(ops),
    .res(res)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  wire last = cnt_ff == 5'h01;
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      cmk_pkg::CMK_IDLE: begin
        if (issue && (is_ucmp || is_scmp)) begin
          nxt_state = cmk_pkg::CMK_CMP;
          nxt_cnt = 5'(`CMK_CMP_CYC);
        end else if (issue && is_clk) begin
          nxt_state = cmk_pkg::CMK_HUB;
          nxt_cnt = hub_wait;
        end
      end
      cmk_pkg::CMK_CMP, cmk_pkg::CMK_HUB: begin
        nxt_cnt = cnt_ff - 5'h01;
        if (last) begin
          nxt_state = cmk_pkg::CMK_IDLE;
        end
      end
      default: begin
        nxt_state = cmk_pkg::CMK_IDLE;
      end
    endcase
  end

  wire cmp_done = state_ff == cmk_pkg::CMK_CMP && last;
  wire clk_done = state_ff == cmk_pkg::CMK_HUB && last;
  wire wb_en = cmp_done && ctrl_ff[`CMK_CTRL_WR];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= cmk_pkg::CMK_IDLE;
      cnt_ff <= 5'h00;
      hub_phase_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      hub_phase_ff <= hub_phase_ff + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_ff <= 32'h00000000;
      ctrl_ff <= 3'h0;
      ill_ff <= 1'b0;
    end else begin
      if (wr_instr) begin
        instr_ff <= new_instr;
        ill_ff <= !(is_ucmp || is_scmp || is_clk) || !idle;
      end
      if (wr_ctrl) begin
        ctrl_ff <= wdata_ff[2:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dst_ff <= 32'h00000000;
      src_ff <= 32'h00000000;
      sgn_ff <= 1'b0;
      dst_idx_ff <= 9'h000;
    end else if (issue) begin
      dst_ff <= dst_val;
      src_ff <= src_val;
      sgn_ff <= is_scmp;
      dst_idx_ff <= f_dst;
    end
  end

  // ----------------------------------------------------------------------
  // Flags, result and clock mode
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_ff <= 1'b0;
      carry_ff <= 1'b0;
      result_ff <= 32'h00000000;
      clkmode_ff <= `CMK_CLKMODE_RST;
    end else begin
      if (cmp_done) begin
        result_ff <= res.diff;
        if (ctrl_ff[`CMK_CTRL_WZ]) begin
          zero_ff <= res.zero;
        end
        if (ctrl_ff[`CMK_CTRL_WC]) begin
          carry_ff <= res.carry;
        end
      end
      if (clk_done) begin
        clkmode_ff <= dst_ff[7:0];
      end
    end
  end

  // Register file: bus writes, and compare write-back when requested
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= 32'h00000000;
      end
    end else if (wb_en) begin
      regs_ff[dst_idx_ff[RW-1:0]] <= res.diff;
    end else if (wr_regf) begin
      regs_ff[wa_idx] <= (regs_ff[wa_idx] & ~wmask) | (wdata_ff & wmask);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (w_take) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= ra_known ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign clock_mode = clkmode_ff;
  assign busy = !idle;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_cmp_four_clocks: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (issue && (is_ucmp || is_scmp)) |=> busy [*4] ##1 !busy)
    else $error("compare not four clocks");

  a_hub_window_min: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (issue && is_clk) |=> busy [*7])
    else $error("clock mode op shorter than seven");

  a_hub_window_max: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (issue && is_clk) |=> ##[7:22] !busy)
    else $error("clock mode op longer than 22");

  a_mode_from_dest: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clk_done |=> clock_mode == $past(dst_ff[7:0]))
    else $error("clock mode not from destination");

  a_mode_only_on_op: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !clk_done |=> $stable(clock_mode))
    else $error("clock mode changed without op");

  a_zero_held: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(cmp_done && ctrl_ff[`CMK_CTRL_WZ]) |=> $stable(zero_ff))
    else $error("zero flag changed without effect");

  a_carry_relation: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (cmp_done && ctrl_ff[`CMK_CTRL_WC]) |=> carry_ff == (sgn_ff ?
      $signed($past(dst_ff)) < $signed($past(src_ff)) :
      $past(dst_ff) < $past(src_ff)))
    else $error("carry flag wrong");

  a_imm_zero_ext: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (issue && f_imm) |=> src_ff[31:9] == 23'h0)
    else $error("immediate not zero extended");

  a_writeback_diff: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wb_en |=> regs_ff[$past(dst_idx_ff[RW-1:0])] ==
      $past(dst_ff) - $past(src_ff))
    else $error("write back not difference");

endmodule

/* verilog/cmk_defs.svh */
// Offsets, field positions, reset values and timing counts for the unit
`ifndef CMK_DEFS_SVH
`define CMK_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CMK_OFF_INSTR 8'h00
`define CMK_OFF_CTRL 8'h04
`define CMK_OFF_STATUS 8'h08
`define CMK_OFF_RESULT 8'h0C
`define CMK_OFF_CLKMODE 8'h10
`define CMK_OFF_REGBASE 8'h80
`define CMK_REGS_BYTES 8'h80

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define CMK_INSTR_HI 31
`define CMK_INSTR_LO 26
`define CMK_ZCRI_HI 25
`define CMK_ZCRI_LO 22
`define CMK_COND_HI 21
`define CMK_COND_LO 18
`define CMK_DEST_HI 17
`define CMK_DEST_LO 9
`define CMK_SRC_HI 8
`define CMK_SRC_LO 0
`define CMK_OP_UCMP 6'h21
`define CMK_OP_SCMP 6'h30
`define CMK_OP_CLK 6'h03
`define CMK_ZCRI_CMP 3'h0
`define CMK_ZCRI_CLK 4'h1
`define CMK_COND_ALWAYS 4'hF

// ----------------------------------------------------------------------
// Control bits and status bits
// ----------------------------------------------------------------------
`define CMK_CTRL_WZ 0
`define CMK_CTRL_WC 1
`define CMK_CTRL_WR 2
`define CMK_ST_BUSY 0
`define CMK_ST_Z 1
`define CMK_ST_C 2
`define CMK_ST_ILL 3
`define CMK_CLKMODE_RST 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CMK_CMP_CYC 4
`define CMK_HUB_MIN 7
`define CMK_HUB_MAX 22
`define CMK_HUB_PERIOD 16
`endif

/* verilog/cmk_pkg.sv */
// Types shared by the compare and clock mode unit
package cmk_pkg;

  typedef enum logic [1:0] {
    CMK_IDLE = 2'b00,
    CMK_CMP = 2'b01,
    CMK_HUB = 2'b10
  } cmk_state_t;

  typedef struct packed {
    logic [31:0] dst;
    logic [31:0] src;
    logic is_signed;
  } cmk_operands_t;

  typedef struct packed {
    logic [31:0] diff;
    logic zero;
    logic carry;
  } cmk_cmp_result_t;

endpackage

/* verilog/cmk_comparator.sv */
// Compare datapath: difference, equality and borrow or signed less-than
`timescale 1ns/1ps
module cmk_comparator (
  input wire cmk_pkg::cmk_operands_t ops,
  output cmk_pkg::cmk_cmp_result_t res
);

  wire [32:0] ext_diff;
  wire signed_lt;
  wire unsigned_lt;

  // ----------------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------------
  assign ext_diff = {1'b0, ops.dst} - {1'b0, ops.src};
  assign unsigned_lt = ext_diff[32];
  assign signed_lt = $signed(ops.dst) < $signed(ops.src);

  assign res.diff = ext_diff[31:0];
  assign res.zero = (ops.dst == ops.src);
  assign res.carry = ops.is_signed ? signed_lt : unsigned_lt;

endmodule

/* tb/cmk_core_model.sv */
// Core-side issuer model: AXI4-Lite master and shared frequency word
`timescale 1ns/1ps
module cmk_core_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Answer-taking delay in cycles
  int stall = 0;
  logic [31:0] shared_long0 = 32'h0;

  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // --------------------------------------------------------------------
  // Bus cycles; released address and data lines show inverted values
  // --------------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (stall == 0);
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bready && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end else if (n >= stall) begin
        s_axi_bready <= 1'b1;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (stall == 0);
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end else if (n >= stall) begin
        s_axi_rready <= 1'b1;
      end
    end
  endtask

  // Software keeps the frequency word itself after a mode change
  task automatic store_freq(input logic [31:0] f);
    shared_long0 = f;
  endtask
endmodule

/* tb/cmk_tb.sv */
// Self-checking bench for the compare and clock mode unit
`timescale 1ns/1ps
`include "cmk_defs.svh"
module tb;
  typedef struct packed {
    logic [4:0] mode;
    logic [31:0] dst;
    logic [31:0] src;
    logic [31:0] diff;
    logic [1:0] zc;
  } cmk_row_t;

  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, clock_mode;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, busy;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, res_exp;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] m;
  logic z_exp, c_exp;
  int n_mismatch = 0;
  int n_checks = 0;
  int run = 0;
  int last_len = 0;
  logic [7:0] pats [3] = '{8'h6F, 8'hA5, 8'h3C};
  logic [31:0] bad [3] = '{{6'h3F, 4'h0, 4'hF, 9'h001, 9'h002},
    {`CMK_OP_UCMP, 4'h0, 4'h0, 9'h001, 9'h002},
    {`CMK_OP_SCMP, 4'h8, 4'hF, 9'h001, 9'h002}};
  // Mode: signed, immediate, write-result, write-carry, write-zero
  cmk_row_t rows [19] = '{
    '{5'h07, 32'h3, 32'h2, 32'h1, 2'h0},
    '{5'h07, 32'h3, 32'h3, 32'h0, 2'h2},
    '{5'h07, 32'h3, 32'h4, 32'hFFFFFFFF, 2'h1},
    '{5'h07, 32'h80000000, 32'h7FFFFFFF, 32'h1, 2'h0},
    '{5'h07, 32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF, 2'h1},
    '{5'h07, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFF, 2'h1},
    '{5'h0F, 32'h5, 32'h1FF, 32'hFFFFFE06, 2'h1},
    '{5'h01, 32'h3, 32'h3, 32'h0, 2'h2},
    '{5'h02, 32'h3, 32'h2, 32'h1, 2'h0},
    '{5'h00, 32'h3, 32'h4, 32'hFFFFFFFF, 2'h1},
    '{5'h14, 32'h80000000, 32'h7FFFFFFF, 32'h1, 2'h1},
    '{5'h17, 32'h80000000, 32'h7FFFFFFF, 32'h1, 2'h1},
    '{5'h17, 32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF, 2'h0},
    '{5'h17, 32'h80000000, 32'h1, 32'h7FFFFFFF, 2'h1},
    '{5'h17, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h80000000, 2'h0},
    '{5'h17, 32'hFFFFFFFE, 32'hFFFFFFFD, 32'h1, 2'h0},
    '{5'h1F, 32'hFFFFFFFF, 32'h1FF, 32'hFFFFFE00, 2'h1},
    '{5'h13, 32'h80000000, 32'h7FFFFFFF, 32'h1, 2'h1},
    '{5'h17, 32'hFFFFFFFE, 32'hFFFFFFFE, 32'h0, 2'h2}};

  cmk_unit u_cmk_unit (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_mode, .busy);

  cmk_core_model u_cmk_core_model (.aclk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_cmk_core_model.axi_write(a, d, r);
    check("bresp", {30'h0, r}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_cmk_core_model.axi_read(a, d, r);
    check("rresp", {30'h0, r}, 32'h0);
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge aclk);
    @(posedge aclk);
    #1;
  endtask

  function automatic logic [7:0] ra(input int i);
    return 8'h80 + 8'(i * 4);
  endfunction

  function automatic logic [31:0] cmpw(input logic [4:0] md,
                                       input logic [8:0] s);
    return {md[4] ? `CMK_OP_SCMP : `CMK_OP_UCMP, `CMK_ZCRI_CMP, md[3],
            `CMK_COND_ALWAYS, 9'h001, s};
  endfunction

  task automatic pulse_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    check("mode_rst", {24'h0, clock_mode}, 32'h0);
    check("busy_rst", {31'h0, busy}, 32'h0);
  endtask

  always @(posedge aclk) begin
    if (busy === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
  end

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    test_done();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    rd(`CMK_OFF_CLKMODE, v);
    check("clkmode_rst", v, 32'h0);
    wr(ra(31), 32'h5);
    foreach (rows[i]) begin
      m = rows[i].mode;
      wr(ra(1), rows[i].dst);
      if (!m[3]) wr(ra(2), rows[i].src);
      wr(`CMK_OFF_CTRL, {29'h0, m[2:0]});
      wr(`CMK_OFF_INSTR, cmpw(m, m[3] ? rows[i].src[8:0] : 9'h002));
      wait_idle();
      check("cmp_len", 32'(last_len), 32'h4);
      if (m[0]) z_exp = rows[i].zc[1];
      if (m[1]) c_exp = rows[i].zc[0];
      rd(`CMK_OFF_STATUS, v);
      check("flags", v, {28'h0, 1'b0, c_exp, z_exp, 1'b0});
      rd(ra(1), v);
      check("dest", v, m[2] ? rows[i].diff : rows[i].dst);
      if (m[2]) begin
        rd(`CMK_OFF_RESULT, v);
        check("result", v, rows[i].diff);
        res_exp = rows[i].diff;
      end
    end
    for (int k = 0; k < 3; k++) begin
      u_cmk_core_model.stall = k;
      wr(ra(3), {24'h123456, pats[k]});
      repeat (k * 5) @(posedge aclk);
      wr(`CMK_OFF_INSTR, {`CMK_OP_CLK, `CMK_ZCRI_CLK, `CMK_COND_ALWAYS,
                          9'h003, 9'h000});
      if (k == 0) wr(`CMK_OFF_INSTR, cmpw(5'h07, 9'h002));
      rd(`CMK_OFF_STATUS, v);
      check("busy_bit", {31'h0, v[0]}, 32'h1);
      wait_idle();
      check("clk_len", {31'h0, last_len >= 7 && last_len <= 22}, 32'h1);
      check("mode_pin", {24'h0, clock_mode}, {24'h0, pats[k]});
      rd(`CMK_OFF_CLKMODE, v);
      check("mode_reg", {24'h0, v[7:0]}, {24'h0, pats[k]});
      rd(ra(3), v);
      check("mode_src", v, {24'h123456, pats[k]});
      rd(`CMK_OFF_RESULT, v);
      check("result_kept", v, res_exp);
      rd(`CMK_OFF_STATUS, v);
      check("flags_kept", {29'h0, v[2:0]}, {29'h0, c_exp, z_exp, 1'b0});
      if (k == 0) check("refused", {31'h0, v[3]}, 32'h1);
      u_cmk_core_model.store_freq(32'h0100 + k);
    end
    rd(ra(1), v);
    check("refused_dest", v, 32'h0);
    check("freq_word", u_cmk_core_model.shared_long0, 32'h0102);
    u_cmk_core_model.stall = 0;
    u_cmk_core_model.axi_write(8'h40, 32'h1, r);
    check("wr_unmapped", {30'h0, r}, 32'h2);
    u_cmk_core_model.axi_read(8'h40, v, r);
    check("rd_unmapped", {30'h0, r}, 32'h2);
    check("rd_unmapped_data", v, 32'h0);
    foreach (bad[i]) begin
      pulse_reset();
      wr(ra(1), 32'h9);
      wr(ra(2), 32'h4);
      wr(`CMK_OFF_CTRL, 32'h7);
      wr(`CMK_OFF_INSTR, bad[i]);
      repeat (3) @(posedge aclk);
      check("bad_busy", {31'h0, busy}, 32'h0);
      rd(`CMK_OFF_STATUS, v);
      check("bad_flag", {28'h0, v[3], 2'h0, v[0]}, 32'h8);
      rd(ra(1), v);
      check("bad_dest", v, 32'h9);
    end
    test_done();
  end
endmodule
